// ---- logic/safe_stop_pkg.sv ----
package safe_stop_pkg;

  // ==========
  // Widths and counts
  localparam int TIME_W      = 16;     // Millisecond timer settings.
  localparam int SPEED_W     = 16;     // Signed speed, r/min.
  localparam int POS_W       = 32;     // Signed position, pulses.
  localparam int CLK_HZ      = 25_000_000;
  localparam int TICK_MS     = 1;      // Timer resolution in milliseconds.
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int RATED_SPEED = 3000;   // Speed that the decel time constant refers to.
  localparam int SYNC_STAGES = 2;

  // ==========
  // Values after reset
  localparam logic [SPEED_W-1:0] RAMP_RESET = 16'h0000;
  localparam logic [POS_W-1:0]   POS_RESET  = 32'h0000_0000;

  // Position allowance scale selected by the unit field.
  localparam logic [1:0] UNIT_X1    = 2'h0;
  localparam logic [1:0] UNIT_X10   = 2'h1;
  localparam logic [1:0] UNIT_X100  = 2'h2;
  localparam logic [1:0] UNIT_X1000 = 2'h3;

  // ==========
  // Types
  typedef enum logic [1:0] {
    STOP_DB,
    STOP_EDB,
    STOP_SD
  } stop_method_t;

  typedef enum logic [2:0] {
    S1_IDLE,
    S1_RAMP,
    S1_BRAKE_WAIT,
    S1_EDB,
    S1_DB
  } stop_one_state_t;

  typedef enum logic [1:0] {
    S2_OFF,
    S2_DECEL,
    S2_SETTLE,
    S2_OBSERVE
  } stop_two_state_t;

  // Configuration settings, held steady by the drive while running.
  typedef struct packed {
    logic               forced_decel_enable;
    logic               electronic_brake_select;  // 1: automatic, 0: disabled.
    logic               small_amplifier;          // 1: 600 W or less.
    logic               torque_mode;
    logic [TIME_W-1:0]  forced_decel_time_constant;
    logic [SPEED_W-1:0] zero_speed_level;
    logic [TIME_W-1:0]  brake_sequence_delay;
    logic [TIME_W-1:0]  electronic_brake_time;
    logic [TIME_W-1:0]  monitor_decel_time;
    logic [SPEED_W-1:0] standstill_speed;
    logic [POS_W-1:0]   position_allowance;
    logic [1:0]         position_allowance_unit;
    logic [TIME_W-1:0]  speed_detect_delay;
    logic [TIME_W-1:0]  position_detect_delay;
  } cfg_t;

  // Drive-stage commands.
  typedef struct packed {
    logic torque_shutoff;
    logic power_off;
    logic dynamic_brake;
    logic electronic_brake;
    logic forced_decel_stop;
  } drive_cmd_t;

endpackage : safe_stop_pkg

// ---- logic/interval_timer.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========
// Interval timer
// Counts ticks while running; clears when stopped, so restarts start fresh.
module interval_timer #(
  parameter int W = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_run,    // Count while high.
  input  wire logic         i_tick,   // One-cycle time base pulse.
  input  wire logic [W-1:0] i_limit,  // Interval length in ticks.
  output logic              o_done    // High once the interval has elapsed.
);

  logic [W-1:0] count_q;  // Elapsed ticks, saturating.

  // Saturates so a long wait never wraps into a false expiry.
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      count_q <= '0;
    end else if (i_tick && count_q != {W{1'b1}}) begin
      count_q <= count_q + 1'b1;
    end
  end

  // A zero limit expires on the first running cycle.
  assign o_done = i_run && (count_q >= i_limit);

endmodule : interval_timer

`default_nettype wire

// ---- logic/safe_stop_monitor.sv ----
// Overview of operation
// (RULE1) Forced stop ramps down with decel time constant.
// (RULE2) Ramp done, slow: wait delay, cut power, brake.
// (RULE3) Monitor time expiry during ramp forces torque shutoff.
// (RULE4) Dynamic brake method brakes immediately on activation.
// (RULE5) Electronic brake, then dynamic after its time.
// (RULE6) Shorter monitor time engages dynamic brake earlier.
// (RULE7) Integrator sets monitor time long enough to stop.
// (RULE8) Stop-two activation starts decel monitoring phase first.
// (RULE9) External controller performs the stop-two deceleration.
// (RULE10) Standstill status high throughout stop observation.
// (RULE11) Released stop-two request ends all observation.
// (RULE12) Both speeds slow, after detect delay, observe.
// (RULE13) Monitor time elapsed also starts standstill observation.
// (RULE14) Command speed excess for delay: torque shutoff.
// (RULE15) Feedback speed excess for delay: torque shutoff.
// (RULE16) Capture position; excess travel triggers torque shutoff.
// (RULE17) Stop-two needs safety-rated motor feedback.
// (RULE18) Position violation waits position detect delay.
// (RULE19) Torque shutoff removes power, engages dynamic brake.
// (RULE20) Stop method from enable, select, capacity, mode, cause.
// (RULE21) Stop-one monitor time elapsed activates torque shutoff.
// (RULE22) First completion wins; capture position once per entry.
// (RULE23) Observation shutoff latched until recovery.
`timescale 1ns/1ns
`default_nettype none

module safe_stop_monitor
  import safe_stop_pkg::*;
#(
  parameter int TICK_LEN  = TICK_CYCLES,  // Clock cycles per timer tick.
  parameter int RATED_SPD = RATED_SPEED   // Speed that the time constant refers to.
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_stop_one_request_n,  // Low runs stop-one (pin).
  input  wire logic                      i_stop_two_request_n,  // Low runs stop-two (pin).
  input  wire logic                      i_alarm_stop,          // Diagnosis error stop.
  input  wire logic                      i_alarm_edb_method,    // Alarm asks for brake stop.
  input  wire logic                      i_recovery,            // Recovery pulse.
  input  wire cfg_t                      i_cfg,                 // Settings.
  input  wire logic signed [SPEED_W-1:0] i_speed_cmd,           // Commanded speed.
  input  wire logic signed [SPEED_W-1:0] i_speed_fb,            // Feedback speed.
  input  wire logic signed [POS_W-1:0]   i_position_fb,         // Feedback position.
  input  wire logic                      i_decel_cmd_done,      // Drive ramp finished.
  output var drive_cmd_t                 o_drive,               // Drive-stage commands.
  output logic [SPEED_W-1:0]             o_decel_speed_cmd,     // Forced ramp magnitude.
  output logic                           o_stop_one_status_out,
  output logic                           o_stop_two_status_out,
  output logic                           o_standstill_status_out
);

  // ==========
  // Elaboration checks
  if (TICK_LEN < 1 || RATED_SPD < 1) begin : g_bad_param
    $error("TICK_LEN and RATED_SPD must be positive");
  end

  // ==========
  // Input synchronisers and time base
  logic [SYNC_STAGES-1:0] s1_sync_q;  // Stop-one request synchroniser.
  logic [SYNC_STAGES-1:0] s2_sync_q;  // Stop-two request synchroniser.
  logic [31:0]            tick_cnt_q; // Prescaler count.
  logic                   tick_q;     // One pulse per millisecond.

  // Requests come from pins, so they pass two flops before any logic.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_sync_q <= '1;
      s2_sync_q <= '1;
    end else begin
      s1_sync_q <= {s1_sync_q[0], i_stop_one_request_n};
      s2_sync_q <= {s2_sync_q[0], i_stop_two_request_n};
    end
  end

  // Millisecond tick for all interval timers.
  always_ff @(posedge i_clk) begin
    if (i_rst || tick_cnt_q == 32'(TICK_LEN - 1)) begin
      tick_cnt_q <= '0;
      tick_q     <= !i_rst;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  wire logic s1_active = !s1_sync_q[SYNC_STAGES-1] || i_alarm_stop;
  wire logic s2_active = !s2_sync_q[SYNC_STAGES-1];

  // ==========
  // Speed and position magnitudes
  function automatic logic [SPEED_W-1:0] abs_spd(input logic signed [SPEED_W-1:0] v);
    abs_spd = v[SPEED_W-1] ? SPEED_W'(-v) : v;
  endfunction : abs_spd

  logic [SPEED_W-1:0] cmd_mag;
  logic [SPEED_W-1:0] fb_mag;
  logic               both_still;
  logic               cmd_fast;
  logic               fb_fast;
  assign cmd_mag    = abs_spd(i_speed_cmd);
  assign fb_mag     = abs_spd(i_speed_fb);
  assign cmd_fast   = cmd_mag > i_cfg.standstill_speed;
  assign fb_fast    = fb_mag > i_cfg.standstill_speed;
  assign both_still = !cmd_fast && !fb_fast;

  // ==========
  // Stop-one method selection
  // Alarms of the brake-stop kind never use the forced ramp.
  stop_method_t method;
  always_comb begin
    if (i_alarm_stop && i_alarm_edb_method) begin
      method = (i_cfg.electronic_brake_select && i_cfg.small_amplifier) ? STOP_EDB
                                                                        : STOP_DB;  // [RULE20]
    end else if (i_cfg.forced_decel_enable && !i_cfg.torque_mode) begin
      method = STOP_SD;  // [RULE20]
    end else if (i_cfg.electronic_brake_select && i_cfg.small_amplifier) begin
      method = STOP_EDB;  // [RULE20]
    end else begin
      method = STOP_DB;  // [RULE20]
    end
  end

  // ==========
  // Stop-one sequence
  stop_one_state_t    s1_q;        // Stop-one state.
  logic [SPEED_W-1:0] ramp_q;      // Forced ramp magnitude.
  logic [31:0]        ramp_acc_q;  // Fractional ramp accumulator.
  logic               s1_sto_q;    // Stop-one torque shutoff.
  logic               mon_done;    // Monitor decel time elapsed.
  logic               edb_done;    // Electronic brake time elapsed.
  logic               brk_done;    // Brake sequence delay elapsed.

  interval_timer #(.W(TIME_W)) u_s1_monitor (
    .i_clk (i_clk), .i_rst (i_rst), .i_run (s1_q != S1_IDLE), .i_tick (tick_q),
    .i_limit (i_cfg.monitor_decel_time), .o_done (mon_done)
  );
  interval_timer #(.W(TIME_W)) u_s1_edb (
    .i_clk (i_clk), .i_rst (i_rst), .i_run (s1_q == S1_EDB), .i_tick (tick_q),
    .i_limit (i_cfg.electronic_brake_time), .o_done (edb_done)
  );
  interval_timer #(.W(TIME_W)) u_s1_brake (
    .i_clk (i_clk), .i_rst (i_rst), .i_run (s1_q == S1_BRAKE_WAIT), .i_tick (tick_q),
    .i_limit (i_cfg.brake_sequence_delay), .o_done (brk_done)
  );

  // The method is latched at activation; a later cause does not switch it mid-stop.
  always_ff @(posedge i_clk) begin
    if (i_rst || !s1_active) begin
      s1_q <= S1_IDLE;
    end else begin
      case (s1_q)
        S1_IDLE: begin
          case (method)
            STOP_SD:  s1_q <= S1_RAMP;   // [RULE1]
            STOP_EDB: s1_q <= S1_EDB;    // [RULE5]
            default:  s1_q <= S1_DB;     // [RULE4]
          endcase
        end
        S1_RAMP: begin
          if (ramp_q == RAMP_RESET && i_decel_cmd_done && fb_mag <= i_cfg.zero_speed_level) begin
            s1_q <= S1_BRAKE_WAIT;  // [RULE2]
          end
        end
        S1_BRAKE_WAIT: begin
          if (brk_done) begin
            s1_q <= S1_DB;  // [RULE2]
          end
        end
        S1_EDB: begin
          // Whichever of the two times is shorter hands over to the dynamic brake.
          if (edb_done || mon_done) begin
            s1_q <= S1_DB;  // [RULE5] [RULE6]
          end
        end
        S1_DB:   s1_q <= S1_DB;
        default: s1_q <= S1_IDLE;
      endcase
    end
  end

  // Torque shutoff on monitor expiry, in any stop-one state, even mid-ramp.
  always_ff @(posedge i_clk) begin
    if (i_rst || !s1_active) begin
      s1_sto_q <= 1'b0;
    end else if (mon_done) begin
      s1_sto_q <= 1'b1;  // [RULE21] [RULE3] [RULE7]
    end
  end

  // Ramp from the captured speed; each tick removes RATED_SPD/time_constant.
  always_ff @(posedge i_clk) begin
    if (i_rst || s1_q == S1_IDLE) begin
      ramp_q     <= s1_active ? fb_mag : RAMP_RESET;
      ramp_acc_q <= '0;
    end else if (s1_q == S1_RAMP && ramp_q != RAMP_RESET) begin
      if (ramp_acc_q >= 32'(i_cfg.forced_decel_time_constant) &&
          i_cfg.forced_decel_time_constant != '0) begin
        ramp_q     <= ramp_q - 1'b1;  // [RULE1]
        ramp_acc_q <= ramp_acc_q - 32'(i_cfg.forced_decel_time_constant);
      end else if (i_cfg.forced_decel_time_constant == '0) begin
        ramp_q <= RAMP_RESET;
      end else if (tick_q) begin
        ramp_acc_q <= ramp_acc_q + 32'(RATED_SPD);
      end
    end
  end

  // ==========
  // Stop-two and standstill observation
  stop_two_state_t  s2_q;       // Stop-two state.
  logic [POS_W-1:0] pos_ref_q;  // Position at observation start.
  logic             s2_sto_q;   // Latched observation shutoff.
  logic             s2_mon_done;
  logic             settle_done;
  logic             cmd_viol;
  logic             fb_viol;
  logic             pos_viol;
  logic [POS_W:0]   pos_delta;
  logic [POS_W-1:0] pos_mag;
  logic [POS_W+9:0] allow_scaled;
  logic             pos_over;

  wire logic observing = (s2_q == S2_OBSERVE);

  interval_timer #(.W(TIME_W)) u_s2_monitor (
    .i_clk (i_clk), .i_rst (i_rst), .i_run (s2_q == S2_DECEL || s2_q == S2_SETTLE),
    .i_tick (tick_q), .i_limit (i_cfg.monitor_decel_time), .o_done (s2_mon_done)
  );
  interval_timer #(.W(TIME_W)) u_s2_settle (
    .i_clk (i_clk), .i_rst (i_rst), .i_run (s2_q == S2_SETTLE && both_still),
    .i_tick (tick_q), .i_limit (i_cfg.speed_detect_delay), .o_done (settle_done)
  );
  interval_timer #(.W(TIME_W)) u_cmd_excess (
    .i_clk (i_clk), .i_rst (i_rst), .i_run (observing && cmd_fast), .i_tick (tick_q),
    .i_limit (i_cfg.speed_detect_delay), .o_done (cmd_viol)
  );
  interval_timer #(.W(TIME_W)) u_fb_excess (
    .i_clk (i_clk), .i_rst (i_rst), .i_run (observing && fb_fast), .i_tick (tick_q),
    .i_limit (i_cfg.speed_detect_delay), .o_done (fb_viol)
  );
  interval_timer #(.W(TIME_W)) u_pos_excess (
    .i_clk (i_clk), .i_rst (i_rst), .i_run (observing && pos_over), .i_tick (tick_q),
    .i_limit (i_cfg.position_detect_delay), .o_done (pos_viol)
  );

  // Stop-two sequence; the monitoring phase always comes first.
  always_ff @(posedge i_clk) begin
    if (i_rst || !s2_active) begin
      s2_q <= S2_OFF;  // [RULE11]
    end else begin
      case (s2_q)
        S2_OFF: s2_q <= S2_DECEL;  // [RULE8] [RULE9] [RULE17]
        S2_DECEL: begin
          if (s2_mon_done) begin
            s2_q <= S2_OBSERVE;  // [RULE13] [RULE22]
          end else if (both_still) begin
            s2_q <= S2_SETTLE;  // [RULE12]
          end
        end
        S2_SETTLE: begin
          if (s2_mon_done || settle_done) begin
            s2_q <= S2_OBSERVE;  // [RULE12] [RULE13] [RULE22]
          end else if (!both_still) begin
            s2_q <= S2_DECEL;
          end
        end
        S2_OBSERVE: s2_q <= S2_OBSERVE;
        default:    s2_q <= S2_OFF;
      endcase
    end
  end

  // Reference is taken only on the edge into observation.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pos_ref_q <= POS_RESET;
    end else if (!observing && s2_active && s2_q != S2_OFF &&
                 (s2_mon_done || (s2_q == S2_SETTLE && settle_done))) begin
      pos_ref_q <= i_position_fb;  // [RULE16] [RULE22]
    end
  end

  // Travel magnitude compared against the scaled allowance.
  always_comb begin
    pos_delta = {i_position_fb[POS_W-1], i_position_fb} - {pos_ref_q[POS_W-1], pos_ref_q};
    pos_mag   = pos_delta[POS_W] ? POS_W'(-pos_delta) : pos_delta[POS_W-1:0];
    case (i_cfg.position_allowance_unit)
      UNIT_X10:   allow_scaled = (POS_W+10)'(i_cfg.position_allowance) * (POS_W+10)'(10);
      UNIT_X100:  allow_scaled = (POS_W+10)'(i_cfg.position_allowance) * (POS_W+10)'(100);
      UNIT_X1000: allow_scaled = (POS_W+10)'(i_cfg.position_allowance) * (POS_W+10)'(1000);
      default:    allow_scaled = (POS_W+10)'(i_cfg.position_allowance);
    endcase
    pos_over = (POS_W+10)'(pos_mag) > allow_scaled;  // [RULE16]
  end

  // Violations latch; only the recovery pulse releases them, set winning.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s2_sto_q <= 1'b0;
    end else if (cmd_viol || fb_viol || pos_viol) begin
      s2_sto_q <= 1'b1;  // [RULE14] [RULE15] [RULE18] [RULE23]
    end else if (i_recovery) begin
      s2_sto_q <= 1'b0;  // [RULE23]
    end
  end

  // ==========
  // Drive commands and status
  // Every output is a flop so the drive stage never sees decode glitches.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_drive                 <= '0;
      o_decel_speed_cmd       <= RAMP_RESET;
      o_stop_one_status_out   <= 1'b0;
      o_stop_two_status_out   <= 1'b0;
      o_standstill_status_out <= 1'b0;
    end else begin
      o_drive.torque_shutoff    <= s1_sto_q || s2_sto_q;
      o_drive.power_off         <= s1_sto_q || s2_sto_q || s1_q == S1_DB;  // [RULE19] [RULE2]
      o_drive.dynamic_brake     <= s1_sto_q || s2_sto_q || s1_q == S1_DB;  // [RULE19] [RULE4]
      o_drive.electronic_brake  <= s1_q == S1_EDB && !s1_sto_q;            // [RULE5]
      o_drive.forced_decel_stop <= s1_q == S1_RAMP || s1_q == S1_BRAKE_WAIT;
      o_decel_speed_cmd         <= ramp_q;                                  // [RULE1]
      o_stop_one_status_out     <= s1_q != S1_IDLE;
      o_stop_two_status_out     <= s2_q != S2_OFF;
      o_standstill_status_out   <= observing;                               // [RULE10]
    end
  end

endmodule : safe_stop_monitor

`default_nettype wire

// ---- bench/safe_stop_monitor_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========
// Stop sequence checker
module safe_stop_monitor_sva
  import safe_stop_pkg::*;
#(
  parameter int TICK_LEN = 4  // Clock cycles per timer tick.
) (
  input wire logic                      i_clk,
  input wire logic                      i_rst,
  input wire logic                      i_stop_two_request_n,
  input wire logic                      i_recovery,
  input wire cfg_t                      i_cfg,
  input wire logic signed [SPEED_W-1:0] i_speed_fb,
  input wire drive_cmd_t                o_drive,
  input wire logic [SPEED_W-1:0]        o_decel_speed_cmd,
  input wire logic                      o_stop_one_status_out,
  input wire logic                      o_stop_two_status_out,
  input wire logic                      o_standstill_status_out
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  int unsigned        s1_q;    // Cycles spent in stop-one.
  int unsigned        fb_q;    // Unbroken cycles of feedback excess while observing.
  logic [SPEED_W-1:0] fb_abs;  // Feedback speed magnitude.
  assign fb_abs = i_speed_fb[SPEED_W-1] ? SPEED_W'(-i_speed_fb) : i_speed_fb;
  // Clears when stop-one ends, so a new entry measures afresh.
  always_ff @(posedge i_clk) begin
    if (i_rst || !o_stop_one_status_out) s1_q <= 0;
    else s1_q <= s1_q + 1;
  end
  // Any dip to the limit restarts the count, as the excess must be continuous.
  always_ff @(posedge i_clk) begin
    if (i_rst || !o_standstill_status_out || fb_abs <= i_cfg.standstill_speed) fb_q <= 0;
    else fb_q <= fb_q + 1;
  end
  tso_power_a: assert property (
    o_drive.torque_shutoff |-> o_drive.power_off && o_drive.dynamic_brake)
    else $error("shutoff without power cut and brake");
  db_method_a: assert property (
    o_stop_one_status_out && !i_cfg.forced_decel_enable && !i_cfg.electronic_brake_select
    |-> o_drive.power_off && o_drive.dynamic_brake) else $error("brake stop not immediate");
  brake_excl_a: assert property (
    !(o_drive.electronic_brake && o_drive.dynamic_brake)) else $error("both brakes at once");
  ramp_slope_a: assert property (
    (o_drive.forced_decel_stop && !o_drive.torque_shutoff
     && i_cfg.forced_decel_time_constant != 16'h0) [*3]
    |-> o_decel_speed_cmd <= $past(o_decel_speed_cmd)
     && {1'b0, $past(o_decel_speed_cmd)} <= {1'b0, o_decel_speed_cmd} + 17'h1)
    else $error("forced ramp not a gentle descent");
  s2_entry_a: assert property (
    $fell(i_stop_two_request_n) ##1 !i_stop_two_request_n [*3]
    |=> o_stop_two_status_out && !o_standstill_status_out) else $error("stop-two entry wrong");
  sos_in_s2_a: assert property (
    o_standstill_status_out |-> o_stop_two_status_out) else $error("observation outside stop-two");
  s2_release_a: assert property (
    i_stop_two_request_n [*6] |-> !o_stop_two_status_out && !o_standstill_status_out)
    else $error("stop-two outlived its request");
  tso_latch_a: assert property (
    o_drive.torque_shutoff && o_standstill_status_out && !i_recovery |=> o_drive.torque_shutoff)
    else $error("observation shutoff not latched");
  s1_time_a: assert property (
    s1_q > (int'(i_cfg.monitor_decel_time) + 2) * TICK_LEN |-> o_drive.torque_shutoff)
    else $error("stop-one monitor time overrun");
  fb_time_a: assert property (
    fb_q > (int'(i_cfg.speed_detect_delay) + 2) * TICK_LEN |-> o_drive.torque_shutoff)
    else $error("feedback excess not shut off");
endmodule : safe_stop_monitor_sva

bind safe_stop_monitor safe_stop_monitor_sva #(.TICK_LEN(TICK_LEN)) u_sva (
  .i_clk(i_clk), .i_rst(i_rst), .i_stop_two_request_n(i_stop_two_request_n),
  .i_recovery(i_recovery), .i_cfg(i_cfg), .i_speed_fb(i_speed_fb), .o_drive(o_drive),
  .o_decel_speed_cmd(o_decel_speed_cmd), .o_stop_one_status_out(o_stop_one_status_out),
  .o_stop_two_status_out(o_stop_two_status_out),
  .o_standstill_status_out(o_standstill_status_out));
`default_nettype wire

// ---- bench/drive_stage_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========
// Drive stage stand-in
module drive_stage_model
  import safe_stop_pkg::*;
(
  input  wire drive_cmd_t                i_drive,       // Commands from the monitor.
  input  wire logic [SPEED_W-1:0]        i_ramp,        // Forced ramp magnitude.
  input  wire logic signed [SPEED_W-1:0] i_ctrl_speed,  // Speed the controller asks for.
  output logic signed [SPEED_W-1:0]      o_speed_fb,    // Encoder speed.
  output logic                           o_ramp_done    // Forced ramp finished.
);
  // Without power the brake holds the shaft, so feedback falls to zero at once.
  always_comb begin
    if (i_drive.power_off) o_speed_fb = '0;
    else if (i_drive.forced_decel_stop) o_speed_fb = $signed(i_ramp);
    else o_speed_fb = i_ctrl_speed;  // The controller does its own slowing.
  end
  // Done only at zero; reporting early would hide a slow ramp.
  assign o_ramp_done = i_drive.forced_decel_stop && i_ramp == '0;
endmodule : drive_stage_model
`default_nettype wire

// ---- bench/safe_stop_monitor_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========
// Stop sequencing bench
module safe_stop_monitor_tb;
  import safe_stop_pkg::*;
  localparam int T = 4;  // Short tick keeps the timed stops brief.
  // Rows: mode {forced, select, small, torque}, alarm, alarm brake, expected {eb, fds, db}.
  localparam logic [8:0] ROWS [10] = '{9'h1E4, 9'h1C2, 9'h1A1, 9'h182, 9'h121,
                                       9'h1DC, 9'h199, 9'h0C4, 9'h081, 9'h051};
  logic                      i_clk, i_rst, s1_n, s2_n, alarm, alarm_edb, recovery, done_fb;
  logic signed [SPEED_W-1:0] cmd, fb_set, fb;
  logic signed [POS_W-1:0]   pos;
  logic [SPEED_W-1:0]        ramp;
  logic                      st1, st2, standstill_observation;
  cfg_t                      cfg;
  drive_cmd_t                drv;
  logic [7:0]                obs;  // Shutoff, power, brakes, ramp, then the three states.
  int                        n_errors, total_checks, n;
  assign obs = {drv, st1, st2, standstill_observation};

  safe_stop_monitor #(.TICK_LEN(T), .RATED_SPD(100)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_stop_one_request_n(s1_n), .i_stop_two_request_n(s2_n),
    .i_alarm_stop(alarm), .i_alarm_edb_method(alarm_edb), .i_recovery(recovery), .i_cfg(cfg),
    .i_speed_cmd(cmd), .i_speed_fb(fb), .i_position_fb(pos), .i_decel_cmd_done(done_fb),
    .o_drive(drv), .o_decel_speed_cmd(ramp), .o_stop_one_status_out(st1),
    .o_stop_two_status_out(st2), .o_standstill_status_out(standstill_observation));
  drive_stage_model u_stage (.i_drive(drv), .i_ramp(ramp), .i_ctrl_speed(fb_set),
    .o_speed_fb(fb), .o_ramp_done(done_fb));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // ==========
  // Access tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask : tick
  // Bounded wait for an output bit to rise; the cycles taken must lie in lo..hi.
  task automatic wait_in(input int k, input int lo, input int hi);
    n = 0;
    while (obs[k] !== 1'b1 && n < hi + 20) begin
      tick(1);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask : wait_in
  task automatic cfg_set(input logic [3:0] mode, input logic [TIME_W-1:0] mdt, tc);
    @(posedge i_clk);
    {cfg.forced_decel_enable, cfg.electronic_brake_select, cfg.small_amplifier,
     cfg.torque_mode} <= mode;
    cfg.monitor_decel_time         <= mdt;  // Long enough to stop unless overrun is wanted.
    cfg.forced_decel_time_constant <= tc;
  endtask : cfg_set
  task automatic s1_run(input int k, input int lo, input int hi);
    @(posedge i_clk);
    s1_n <= 1'b0;
    wait_in(k, lo, hi);
  endtask : s1_run
  task automatic rel(input string name);
    @(posedge i_clk);
    s1_n  <= 1'b1;
    s2_n  <= 1'b1;
    alarm <= 1'b0;
    tick(8);
    chk(32'(obs[2:0]), 32'h0);
    $display("test %s done", name);
  endtask : rel
  task automatic recover();
    @(posedge i_clk);
    recovery <= 1'b1;
    @(posedge i_clk);
    recovery <= 1'b0;
    tick(3);
    chk(32'(obs[7]), 32'h0);
  endtask : recover
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  initial begin
    #(40 * 8000);
    n_errors++;
    results();
  end

  // ==========
  // Test sequence
  initial begin
    {i_rst, s1_n, s2_n, alarm, alarm_edb, recovery} = 6'h38;
    {cmd, fb_set, pos, n_errors, total_checks} = '0;
    pos = 32'sh0000_1000;
    cfg = '0;
    cfg.electronic_brake_time   = 16'h0006;
    cfg.standstill_speed        = 16'h000A;
    cfg.position_allowance      = 32'h0000_0005;
    cfg.position_allowance_unit = UNIT_X10;
    {cfg.speed_detect_delay, cfg.position_detect_delay} = 32'h0003_0003;
    {cfg.zero_speed_level, cfg.brake_sequence_delay}    = 32'h0005_0003;
    repeat (2) @(posedge i_clk);
    i_rst  <= 1'b0;
    fb_set <= 16'sh0028;
    for (int i = 0; i < 10; i++) begin
      cfg_set(ROWS[i][8:5], 16'h0032, 16'h0064);
      @(posedge i_clk);
      if (ROWS[i][4]) {alarm, alarm_edb} <= {1'b1, ROWS[i][3]};
      else s1_n <= 1'b0;
      tick(6);
      chk(32'(obs[7:3]), 32'({1'b0, ROWS[i][0], ROWS[i][0], ROWS[i][2:1]}));
      rel("stop method");
    end
    cfg_set(4'h0, 16'h000A, 16'h0064);
    s1_run(7, 9 * T, 11 * T + 8);
    chk(32'(obs[6:5]), 32'h3);
    rel("brake stop");
    cfg_set(4'h6, 16'h0032, 16'h0064);
    s1_run(5, 5 * T, 7 * T + 8);
    chk(32'(obs[4]), 32'h0);
    rel("electronic brake");
    cfg_set(4'h6, 16'h0003, 16'h0064);
    s1_run(5, 2 * T, 4 * T + 8);
    rel("short monitor");
    cfg_set(4'h8, 16'h0064, 16'h0064);
    s1_run(6, 41 * T, 46 * T + 10);
    chk(32'(obs[7]), 32'h0);
    rel("forced ramp");
    cfg_set(4'h8, 16'h0008, 16'h03E8);
    s1_run(7, 7 * T, 9 * T + 8);
    rel("ramp overrun");
    cfg_set(4'h0, 16'h0028, 16'h0064);
    @(posedge i_clk);
    {fb_set, s2_n} <= {16'sh0000, 1'b0};
    tick(6);
    chk(32'(obs[1:0]), 32'h2);
    wait_in(0, T, 4 * T + 4);
    @(posedge i_clk);
    pos <= 32'sh0000_1032;
    tick(8 * T);
    chk(32'(obs[7]), 32'h0);
    @(posedge i_clk);
    pos <= 32'sh0000_1033;
    wait_in(7, 2 * T, 4 * T + 6);
    @(posedge i_clk);
    pos <= 32'sh0000_1000;
    tick(20);
    chk(32'(obs[7]), 32'h1);
    rel("position drift");
    chk(32'(obs[7]), 32'h1);
    recover();
    cfg_set(4'h0, 16'h000A, 16'h0064);
    @(posedge i_clk);
    {cmd, s2_n} <= {16'sh0014, 1'b0};
    wait_in(0, 9 * T, 11 * T + 8);
    wait_in(7, 0, 4 * T + 6);
    rel("command excess");
    recover();
    cfg_set(4'h0, 16'h0028, 16'h0064);
    @(posedge i_clk);
    {cmd, s2_n} <= {16'sh0000, 1'b0};
    wait_in(0, 3 * T, 5 * T);
    @(posedge i_clk);
    fb_set <= 16'shFFEC;
    wait_in(7, 2 * T, 4 * T + 6);
    rel("feedback excess");
    recover();
    results();
  end
endmodule : safe_stop_monitor_tb
`default_nettype wire
